/* verilog/uhtc_top.sv */
// usb host transaction control: apb register file and transaction sequencer
// feeding the packet engine. assumes a 100 MHz pclk, an apb master, and a
// packet engine that acknowledges tokens and reports each transaction's end.
`timescale 1ns/100ps
`default_nettype none
`include "uhtc_map.svh"

// Overview of operation
// [R1] software writes word aligned buffer start addresses
// [R2] preamble enable precedes low speed traffic
// [R3] auto frame start sends sof each frame
// [R4] without auto, software may issue sof token
// [R5] token upper nibble selects token pid
// [R6] token lower nibble selects target endpoint
// [R7] accept in data only on expected pid
// [R8] rx auto toggle flips after good reception
// [R9] rx no handshake bit suppresses ack
// [R10] tx length gives payload byte count
// [R11] tx toggle selects data1 or data0
// [R12] tx auto toggle flips after good send
// [R13] tx no handshake bit expects no ack
// [R14] dual tx buffer half chosen by toggle
// [R15] dual rx buffer half chosen by toggle
// [R16] failed transactions never flip toggles
module uhtc_top import uhtc_pkg::*; #(
    parameter int FRAME_CYCLES = `UHTC_FRAME_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port and endpoint mode from neighbouring registers
    input wire logic low_speed,
    input wire logic tx_dual_buf,
    input wire logic rx_dual_buf,
    // token request to the packet engine
    output logic tok_req,
    output logic [3:0] tok_pid,
    output logic [3:0] tok_endp,
    output logic tok_pre,
    input wire logic tok_ack,
    // data phase setup
    output logic [3:0] tx_data_pid,
    output logic [7:0] tx_len,
    output logic [14:0] tx_addr,
    output logic [14:0] rx_addr,
    output logic tx_expect_ack,
    output logic rx_send_ack,
    // received data pid check and transaction end
    input wire logic rx_pid_stb,
    input wire logic [3:0] rx_pid,
    output logic rx_pid_ok,
    input wire logic xfer_done,
    input wire logic xfer_ok,
    output logic busy
);

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    if (FRAME_CYCLES < 2 || FRAME_CYCLES > (1 << `UHTC_FRAME_CNT_W)) begin : g_bad_frame
        $error("FRAME_CYCLES out of range for the frame counter");
    end

    localparam logic [`UHTC_FRAME_CNT_W-1:0] FRAME_LAST = `UHTC_FRAME_CNT_W'(FRAME_CYCLES - 1);

    // ------------------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------------------
    uhtc_state_s_t s_r;
    uhtc_state_s_t s_nxt;
    logic [31:0] rd_val;
    logic hit;
    logic wr;
    logic frame_tick;
    logic is_in;
    logic [3:0] exp_pid;
    logic pid_match;

    assign wr = psel && penable && pwrite;
    assign frame_tick = s_r.sof_en && (s_r.frame_cnt == FRAME_LAST);
    assign is_in = (s_r.token[7:4] == `UHTC_PID_IN);
    // expected data pid from the receive toggle
    assign exp_pid = s_r.rx_tog ? `UHTC_PID_DATA1 : `UHTC_PID_DATA0; // R7
    assign pid_match = (rx_pid == exp_pid); // R7

    // read mux and address decode
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            `UHTC_OFF_RX_START: rd_val[15:0] = s_r.rx_start;
            `UHTC_OFF_TX_START: rd_val[15:0] = s_r.tx_start;
            `UHTC_OFF_AUX: begin
                rd_val[`UHTC_AUX_PRE_BIT] = s_r.pre_en;
                rd_val[`UHTC_AUX_SOF_BIT] = s_r.sof_en;
            end
            `UHTC_OFF_TOKEN: rd_val[7:0] = s_r.token;
            `UHTC_OFF_RX_CTRL: begin
                rd_val[`UHTC_RX_TOG_BIT] = s_r.rx_tog;
                rd_val[`UHTC_RX_AUTO_BIT] = s_r.rx_auto;
                rd_val[`UHTC_RX_RES_BIT] = s_r.rx_res;
            end
            `UHTC_OFF_TX_LEN: rd_val[7:0] = s_r.tx_len;
            `UHTC_OFF_TX_CTRL: begin
                rd_val[`UHTC_TX_TOG_BIT] = s_r.tx_tog;
                rd_val[`UHTC_TX_AUTO_BIT] = s_r.tx_auto;
                rd_val[`UHTC_TX_RES_BIT] = s_r.tx_res;
            end
            `UHTC_OFF_STATUS: rd_val[2:0] = {s_r.st != ST_IDLE, s_r.last_ok, s_r.rx_match};
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // read data is captured in the setup phase
        if (psel && !penable) begin
            s_nxt.prdata = rd_val;
        end
        // software writes; hardware toggle flips below take precedence
        if (wr && pstrb[0]) begin
            unique case (paddr)
                `UHTC_OFF_RX_START: s_nxt.rx_start[7:0] = pwdata[7:0];
                `UHTC_OFF_TX_START: s_nxt.tx_start[7:0] = pwdata[7:0];
                `UHTC_OFF_AUX: begin
                    s_nxt.pre_en = pwdata[`UHTC_AUX_PRE_BIT];
                    s_nxt.sof_en = pwdata[`UHTC_AUX_SOF_BIT];
                end
                `UHTC_OFF_TOKEN: s_nxt.token = pwdata[7:0];
                `UHTC_OFF_RX_CTRL: begin
                    s_nxt.rx_tog = pwdata[`UHTC_RX_TOG_BIT];
                    s_nxt.rx_auto = pwdata[`UHTC_RX_AUTO_BIT];
                    s_nxt.rx_res = pwdata[`UHTC_RX_RES_BIT];
                end
                `UHTC_OFF_TX_LEN: s_nxt.tx_len = pwdata[7:0];
                `UHTC_OFF_TX_CTRL: begin
                    s_nxt.tx_tog = pwdata[`UHTC_TX_TOG_BIT];
                    s_nxt.tx_auto = pwdata[`UHTC_TX_AUTO_BIT];
                    s_nxt.tx_res = pwdata[`UHTC_TX_RES_BIT];
                end
                default: ;
            endcase
        end
        if (wr && pstrb[1]) begin
            if (paddr == `UHTC_OFF_RX_START) begin
                s_nxt.rx_start[15:8] = pwdata[15:8];
            end
            if (paddr == `UHTC_OFF_TX_START) begin
                s_nxt.tx_start[15:8] = pwdata[15:8];
            end
        end
        // frame timer runs only while automatic sof is on
        if (!s_r.sof_en) begin
            s_nxt.frame_cnt = '0;
            s_nxt.sof_pend = 1'b0;
        end else if (frame_tick) begin
            s_nxt.frame_cnt = '0;
        end else begin
            s_nxt.frame_cnt = s_r.frame_cnt + 1'b1;
        end
        // transaction sequencer
        unique case (s_r.st)
            ST_IDLE: begin
                // a sof queued just as the enable was cleared is dropped, never sent
                if (s_r.sof_pend && s_r.sof_en) begin
                    s_nxt.st = ST_TOKEN;
                    s_nxt.cur_sof = 1'b1; // R3
                    s_nxt.sof_pend = 1'b0;
                end else if (s_r.start_pend) begin
                    s_nxt.st = ST_TOKEN;
                    s_nxt.cur_sof = 1'b0;
                    s_nxt.start_pend = 1'b0;
                    s_nxt.rx_match = 1'b0;
                end
            end
            ST_TOKEN: begin
                if (tok_ack) begin
                    // a software sof token has no data phase
                    if (s_r.cur_sof || s_r.token[7:4] == `UHTC_PID_SOF) begin // R4
                        s_nxt.st = ST_IDLE;
                        s_nxt.cur_sof = 1'b0;
                    end else begin
                        s_nxt.st = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (rx_pid_stb && pid_match) begin
                    s_nxt.rx_match = 1'b1; // R7
                end
                if (xfer_done) begin
                    s_nxt.st = ST_IDLE;
                    if (is_in) begin
                        s_nxt.last_ok = xfer_ok && (s_r.rx_match || (rx_pid_stb && pid_match));
                        if (xfer_ok && (s_r.rx_match || (rx_pid_stb && pid_match)) && s_r.rx_auto) begin
                            s_nxt.rx_tog = !s_r.rx_tog; // R8 R16
                        end
                    end else begin
                        s_nxt.last_ok = xfer_ok;
                        if (xfer_ok && s_r.tx_auto) begin
                            s_nxt.tx_tog = !s_r.tx_tog; // R12 R16
                        end
                    end
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        // frame tick and software start are set after the clears: set wins
        if (frame_tick) begin
            s_nxt.sof_pend = 1'b1; // R3
        end
        if (wr && pstrb[0] && paddr == `UHTC_OFF_TOKEN && s_r.st == ST_IDLE) begin
            s_nxt.start_pend = 1'b1; // R4
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: ST_IDLE, rx_start: `UHTC_RST_START, tx_start: `UHTC_RST_START,
                     token: `UHTC_RST_BYTE, tx_len: `UHTC_RST_BYTE, frame_cnt: '0,
                     prdata: 32'h0000_0000, default: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign busy = (s_r.st != ST_IDLE);
    assign tok_req = (s_r.st == ST_TOKEN);
    assign tok_pid = s_r.cur_sof ? `UHTC_PID_SOF : s_r.token[7:4]; // R5
    assign tok_endp = s_r.token[3:0]; // R6
    assign tok_pre = s_r.pre_en && low_speed; // R2
    assign tx_data_pid = s_r.tx_tog ? `UHTC_PID_DATA1 : `UHTC_PID_DATA0; // R11
    assign tx_len = s_r.tx_len; // R10
    // only the low fifteen address bits are used; alignment is software's duty
    assign tx_addr = s_r.tx_start[14:0] + ((tx_dual_buf && s_r.tx_tog) ? `UHTC_HALF_OFFSET : 15'h0000); // R1 R14
    assign rx_addr = s_r.rx_start[14:0] + ((rx_dual_buf && s_r.rx_tog) ? `UHTC_HALF_OFFSET : 15'h0000); // R1 R15
    assign tx_expect_ack = !s_r.tx_res; // R13
    assign rx_send_ack = !s_r.rx_res; // R9
    assign rx_pid_ok = rx_pid_stb && pid_match; // R7

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence sof_waiting;
        s_r.sof_pend && s_r.sof_en && s_r.st == ST_IDLE;
    endsequence
    sequence sof_token;
        tok_req && tok_pid == `UHTC_PID_SOF;
    endsequence
    sequence good_in_end;
        s_r.st == ST_DATA && is_in && xfer_done && xfer_ok && s_r.rx_match && s_r.rx_auto;
    endsequence
    sequence good_out_end;
        s_r.st == ST_DATA && !is_in && xfer_done && xfer_ok && s_r.tx_auto;
    endsequence

    pre_gate_a: assert property (tok_req |-> tok_pre == (s_r.pre_en && low_speed)) else $error("preamble flag wrong"); // R2
    sof_auto_a: assert property (sof_waiting |=> sof_token) else $error("auto sof not issued"); // R3
    sof_manual_a: assert property (!s_r.sof_en && s_r.st == ST_IDLE |=> !s_r.cur_sof) else $error("auto sof while disabled"); // R4
    token_pid_a: assert property (tok_req && !s_r.cur_sof |-> tok_pid == s_r.token[7:4]) else $error("token pid wrong"); // R5
    token_endp_a: assert property (tok_req |-> tok_endp == s_r.token[3:0]) else $error("endpoint wrong"); // R6
    rx_accept_a: assert property (rx_pid_stb |-> rx_pid_ok == (rx_pid == (s_r.rx_tog ? 4'hB : 4'h3))) else $error("rx pid check wrong"); // R7
    rx_flip_a: assert property (good_in_end |=> s_r.rx_tog != $past(s_r.rx_tog)) else $error("rx toggle not flipped"); // R8
    rx_ack_a: assert property (rx_send_ack == !s_r.rx_res) else $error("rx handshake policy wrong"); // R9
    tx_len_a: assert property (tx_len == s_r.tx_len) else $error("tx length wrong"); // R10
    tx_pid_a: assert property (tx_data_pid == (s_r.tx_tog ? 4'hB : 4'h3)) else $error("tx data pid wrong"); // R11
    tx_flip_a: assert property (good_out_end |=> s_r.tx_tog != $past(s_r.tx_tog)) else $error("tx toggle not flipped"); // R12
    tx_ack_a: assert property (tx_expect_ack == !s_r.tx_res) else $error("tx handshake policy wrong"); // R13
    tx_half_a: assert property (tx_addr == s_r.tx_start[14:0] + ((tx_dual_buf && s_r.tx_tog) ? 15'h0040 : 15'h0000))
        else $error("tx half wrong"); // R14
    rx_half_a: assert property (rx_addr == s_r.rx_start[14:0] + ((rx_dual_buf && s_r.rx_tog) ? 15'h0040 : 15'h0000))
        else $error("rx half wrong"); // R15
    no_flip_a: assert property (s_r.st == ST_DATA && xfer_done && !xfer_ok && !wr |=> $stable(s_r.rx_tog) && $stable(s_r.tx_tog))
        else $error("toggle flipped on failure"); // R16

endmodule : uhtc_top
`default_nettype wire

/* verilog/uhtc_map.svh */
// register map, field positions, reset values and timing counts of the
// usb host transaction control block; included by the package and the top.
`ifndef UHTC_MAP_SVH
`define UHTC_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define UHTC_OFF_RX_START 12'h000
`define UHTC_OFF_TX_START 12'h004
`define UHTC_OFF_AUX 12'h008
`define UHTC_OFF_TOKEN 12'h00C
`define UHTC_OFF_RX_CTRL 12'h010
`define UHTC_OFF_TX_LEN 12'h014
`define UHTC_OFF_TX_CTRL 12'h018
`define UHTC_OFF_STATUS 12'h01C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define UHTC_AUX_PRE_BIT 7
`define UHTC_AUX_SOF_BIT 6
`define UHTC_RX_TOG_BIT 7
`define UHTC_RX_AUTO_BIT 4
`define UHTC_RX_RES_BIT 2
`define UHTC_TX_TOG_BIT 6
`define UHTC_TX_AUTO_BIT 4
`define UHTC_TX_RES_BIT 0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define UHTC_RST_START 16'h0000
`define UHTC_RST_BYTE 8'h00

// ----------------------------------------------------------------------------
// packet ids and buffer layout
// ----------------------------------------------------------------------------
`define UHTC_PID_OUT 4'h1
`define UHTC_PID_IN 4'h9
`define UHTC_PID_SETUP 4'hD
`define UHTC_PID_SOF 4'h5
`define UHTC_PID_DATA0 4'h3
`define UHTC_PID_DATA1 4'hB
`define UHTC_HALF_OFFSET 15'h0040

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define UHTC_CLK_MHZ 100
`define UHTC_FRAME_US 1000
`define UHTC_FRAME_CYCLES (`UHTC_FRAME_US * `UHTC_CLK_MHZ)
`define UHTC_FRAME_CNT_W 20

`endif

/* verilog/uhtc_pkg.sv */
// types shared by the usb host transaction control block.
// assumes the map header sits beside it in verilog/.
`default_nettype none
`include "uhtc_map.svh"

package uhtc_pkg;

    // ------------------------------------------------------------------------
    // transaction sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TOKEN = 3'b010,
        ST_DATA = 3'b100
    } uhtc_state_t;

    // ------------------------------------------------------------------------
    // whole state of the block
    // ------------------------------------------------------------------------
    typedef struct packed {
        uhtc_state_t st;
        logic [15:0] rx_start;
        logic [15:0] tx_start;
        logic pre_en;
        logic sof_en;
        logic [7:0] token;
        logic rx_tog;
        logic rx_auto;
        logic rx_res;
        logic [7:0] tx_len;
        logic tx_tog;
        logic tx_auto;
        logic tx_res;
        logic start_pend;
        logic sof_pend;
        logic cur_sof;
        logic rx_match;
        logic last_ok;
        logic [`UHTC_FRAME_CNT_W-1:0] frame_cnt;
        logic [31:0] prdata;
    } uhtc_state_s_t;

endpackage : uhtc_pkg
`default_nettype wire

/* bench/uhtc_engine_model.sv */
// packet engine model: takes each token and plays the usb data phase back.
// assumes the block raises one token request at a time and waits for its end.
`timescale 1ns/100ps
`default_nettype none
`include "uhtc_map.svh"
module uhtc_engine_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // token side
    input wire logic tok_req,
    input wire logic [3:0] tok_pid,
    input wire logic [3:0] tok_endp,
    output logic tok_ack,
    // data phase
    output logic rx_pid_stb,
    output logic [3:0] rx_pid,
    input wire logic rx_pid_ok,
    output logic xfer_done,
    output logic xfer_ok,
    // scenario control and capture
    input wire logic [3:0] ack_dly,
    input wire logic [3:0] reply_pid,
    input wire logic reply_ok,
    output logic [3:0] took_pid,
    output logic [3:0] took_endp,
    output logic pid_ok_seen
);
    logic [1:0] st;
    logic [3:0] cnt;
    // one step per clock; released data lines flip every cycle so stale values never pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= 2'd0;
            cnt <= 4'h0;
            tok_ack <= 1'b0;
            rx_pid_stb <= 1'b0;
            xfer_done <= 1'b0;
            rx_pid <= 4'h0;
            xfer_ok <= 1'b0;
        end else begin
            tok_ack <= 1'b0;
            rx_pid_stb <= 1'b0;
            xfer_done <= 1'b0;
            rx_pid <= ~rx_pid;
            xfer_ok <= ~xfer_ok;
            case (st)
                2'd0: if (tok_req) begin
                    took_pid <= tok_pid;
                    took_endp <= tok_endp;
                    cnt <= ack_dly;
                    st <= 2'd1;
                end
                2'd1: if (cnt == 4'h0) begin
                    tok_ack <= 1'b1;
                    st <= 2'd2;
                end else begin
                    cnt <= cnt - 4'h1;
                end
                2'd2: if (took_pid == `UHTC_PID_SOF) begin
                    st <= 2'd0;
                end else if (took_pid == `UHTC_PID_IN) begin
                    rx_pid_stb <= 1'b1;
                    rx_pid <= reply_pid;
                    st <= 2'd3;
                end else begin
                    xfer_done <= 1'b1;
                    xfer_ok <= reply_ok;
                    st <= 2'd0;
                end
                default: begin
                    pid_ok_seen <= rx_pid_ok;
                    xfer_done <= 1'b1;
                    xfer_ok <= reply_ok;
                    st <= 2'd0;
                end
            endcase
        end
    end
endmodule : uhtc_engine_model
`default_nettype wire

/* bench/usb_host_transaction_control_test.sv */
// testbench of the usb host transaction control block over apb.
// assumes the engine model on the far side and a short frame count.
`timescale 1ns/100ps
`default_nettype none
`include "uhtc_map.svh"
module usb_host_transaction_control_test;
    localparam int FRAME = 50;
    localparam logic [3:0] PL [3] = '{`UHTC_PID_OUT, `UHTC_PID_IN, `UHTC_PID_SETUP};
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, low_speed, tx_dual_buf, rx_dual_buf, reply_ok, err;
    logic pready, pslverr, tok_req, tok_pre, tok_ack, rx_pid_stb, rx_pid_ok, xfer_done, xfer_ok;
    logic busy, tx_expect_ack, rx_send_ack, pid_ok_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, tok_pid, tok_endp, tx_data_pid, rx_pid, took_pid, took_endp, ack_dly, reply_pid;
    logic [7:0] tx_len;
    logic [14:0] tx_addr, rx_addr;
    int fails = 0;
    int comparisons = 0;

    // ------------------------------------------------------------------------
    // clock, block and far side
    // ------------------------------------------------------------------------
    always #5 pclk = ~pclk;
    uhtc_top #(.FRAME_CYCLES(FRAME)) u_dut (.*);
    uhtc_engine_model u_eng (.*);

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out

    // one apb transfer; read data and error left in rd and err
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rdchk

    // bounded wait for the sequencer to reach a busy level
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (busy !== lvl) begin
            fails++;
            close_out();
        end
    endtask : wait_busy

    task automatic xact(input logic [7:0] tok);
        apb(1'b1, `UHTC_OFF_TOKEN, {24'h00_0000, tok});
        wait_busy(1'b1);
        wait_busy(1'b0);
    endtask : xact

    // ------------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------------
    initial begin
        int n;
        {presetn, psel, penable, pwrite, low_speed, tx_dual_buf, rx_dual_buf} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        ack_dly = 4'h2;
        reply_pid = `UHTC_PID_DATA0;
        reply_ok = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rdchk("reset value", 12'(4 * i), 32'h0000_0000);
        chk("data pid", 32'(`UHTC_PID_DATA0), 32'(tx_data_pid));
        $display("test reset done");
        apb(1'b1, `UHTC_OFF_RX_START, 32'h0000_FFFC);
        apb(1'b1, `UHTC_OFF_TX_START, 32'h0000_1234);
        apb(1'b1, `UHTC_OFF_TX_LEN, 32'h0000_00FF);
        rdchk("rx start", `UHTC_OFF_RX_START, 32'h0000_FFFC);
        rdchk("tx length", `UHTC_OFF_TX_LEN, 32'h0000_00FF);
        @(negedge pclk);
        chk("rx addr", 32'h0000_7FFC, 32'(rx_addr));
        chk("tx length port", 32'h0000_00FF, 32'(tx_len));
        rdchk("unmapped", 12'h020, 32'h0000_0000);
        chk("slave error", 32'h0000_0001, 32'(err));
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            ack_dly <= 4'(i * 4);
            xact({PL[i], 4'(i + 5)});
            chk("token pid", 32'(PL[i]), 32'(took_pid));
            chk("endpoint", 32'(i + 5), 32'(took_endp));
        end
        $display("test token done");
        apb(1'b1, `UHTC_OFF_AUX, 32'h0000_0080);
        low_speed <= 1'b1;
        @(negedge pclk);
        chk("preamble on", 32'h0000_0001, 32'(tok_pre));
        apb(1'b1, `UHTC_OFF_AUX, 32'h0000_0000);
        @(negedge pclk);
        chk("preamble off", 32'h0000_0000, 32'(tok_pre));
        $display("test preamble done");
        apb(1'b1, `UHTC_OFF_TX_CTRL, 32'h0000_0010);
        tx_dual_buf <= 1'b1;
        xact(8'h12);
        rdchk("tx ctrl flip", `UHTC_OFF_TX_CTRL, 32'h0000_0050);
        reply_ok <= 1'b0;
        @(negedge pclk);
        chk("tx data pid", 32'(`UHTC_PID_DATA1), 32'(tx_data_pid));
        chk("tx half", 32'h0000_1274, 32'(tx_addr));
        xact(8'hD2);
        rdchk("tx ctrl failed", `UHTC_OFF_TX_CTRL, 32'h0000_0050);
        apb(1'b1, `UHTC_OFF_TX_CTRL, 32'h0000_0001);
        reply_ok <= 1'b1;
        xact(8'h12);
        rdchk("tx ctrl manual", `UHTC_OFF_TX_CTRL, 32'h0000_0001);
        @(negedge pclk);
        chk("tx expect ack", 32'h0000_0000, 32'(tx_expect_ack));
        chk("tx data pid", 32'(`UHTC_PID_DATA0), 32'(tx_data_pid));
        chk("tx half", 32'h0000_1234, 32'(tx_addr));
        $display("test transmit done");
        apb(1'b1, `UHTC_OFF_RX_START, 32'h0000_1000);
        apb(1'b1, `UHTC_OFF_RX_CTRL, 32'h0000_0010);
        rx_dual_buf <= 1'b1;
        xact(8'h93);
        chk("pid accepted", 32'h0000_0001, 32'(pid_ok_seen));
        rdchk("rx ctrl flip", `UHTC_OFF_RX_CTRL, 32'h0000_0090);
        @(negedge pclk);
        chk("rx half", 32'h0000_1040, 32'(rx_addr));
        xact(8'h93);
        chk("pid refused", 32'h0000_0000, 32'(pid_ok_seen));
        rdchk("rx ctrl kept", `UHTC_OFF_RX_CTRL, 32'h0000_0090);
        reply_pid <= `UHTC_PID_DATA1;
        xact(8'h93);
        chk("pid data1", 32'h0000_0001, 32'(pid_ok_seen));
        rdchk("rx ctrl back", `UHTC_OFF_RX_CTRL, 32'h0000_0010);
        apb(1'b1, `UHTC_OFF_RX_CTRL, 32'h0000_0004);
        reply_pid <= `UHTC_PID_DATA0;
        xact(8'h93);
        rdchk("rx ctrl manual", `UHTC_OFF_RX_CTRL, 32'h0000_0004);
        @(negedge pclk);
        chk("rx first half", 32'h0000_1000, 32'(rx_addr));
        chk("rx send ack", 32'h0000_0000, 32'(rx_send_ack));
        $display("test receive done");
        apb(1'b1, `UHTC_OFF_AUX, 32'h0000_0040);
        n = 0;
        while (!(tok_req === 1'b1 && tok_pid === `UHTC_PID_SOF) && n < FRAME + 20) begin
            @(posedge pclk);
            n++;
        end
        chk("auto frame start", 32'(`UHTC_PID_SOF), 32'(tok_pid));
        apb(1'b1, `UHTC_OFF_AUX, 32'h0000_0000);
        wait_busy(1'b0);
        n = 0;
        repeat (3 * FRAME) begin
            @(posedge pclk);
            if (tok_req !== 1'b0) n++;
        end
        chk("no auto frame start", 32'h0000_0000, 32'(n));
        xact(8'h50);
        chk("manual frame start", 32'(`UHTC_PID_SOF), 32'(took_pid));
        $display("test frame start done");
        close_out();
    end
endmodule : usb_host_transaction_control_test
`default_nettype wire
